/* rtl/rtc_top.sv */
`timescale 1ns/1ns
`include "rtc_regs.svh"

module rtc_top #(
  parameter int unsigned PRESC_DIV = `RTC_PRESC_DIV
) (
  // Always-on clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Crystal pin.
  input wire logic xtal,
  // Time load.
  input wire logic time_wr,
  input wire rtc_pkg::rtc_day_t time_day,
  input wire rtc_pkg::rtc_hour_t time_hour,
  input wire rtc_pkg::rtc_sec_t time_min,
  input wire rtc_pkg::rtc_sec_t time_sec,
  // Alarm load and enables.
  input wire logic alarm_wr,
  input wire rtc_pkg::rtc_day_t alarm_day,
  input wire rtc_pkg::rtc_hour_t alarm_hour,
  input wire rtc_pkg::rtc_sec_t alarm_min,
  input wire rtc_pkg::rtc_sec_t alarm_sec,
  input wire logic [1:0] alarm_en,
  // Stopwatch control.
  input wire logic sw_wr,
  input wire rtc_pkg::rtc_sw_t sw_value,
  input wire logic sw_en,
  // Flag control.
  input wire rtc_pkg::rtc_ev_t irq_en,
  input wire rtc_pkg::rtc_ev_t wake_en,
  input wire rtc_pkg::rtc_ev_t stat_clr,
  // Current state.
  output rtc_pkg::rtc_day_t cur_day,
  output rtc_pkg::rtc_hour_t cur_hour,
  output rtc_pkg::rtc_sec_t cur_min,
  output rtc_pkg::rtc_sec_t cur_sec,
  output rtc_pkg::rtc_sw_t sw_count,
  output rtc_pkg::rtc_ev_t stat_flags,
  output logic irq,
  output logic wake_req
);
  import rtc_pkg::*;

  // Wraps at the last value, otherwise counts up by one.
  function automatic logic [14:0] rtc_step(input logic [14:0] v, input logic [14:0] last);
    return (v == last) ? 15'h0000 : v + 15'h0001;
  endfunction : rtc_step

  rtc_tick_if tk ();

  rtc_sec_t sec_q, min_q, sec_n, min_n;
  rtc_hour_t hour_q, hour_n;
  rtc_day_t day_q, day_n;
  rtc_day_t al_day_q;
  rtc_hour_t al_hour_q;
  rtc_sec_t al_min_q, al_sec_q;
  rtc_sw_t sw_q;
  rtc_sw_state_t sw_st_q, sw_st_d;
  rtc_ev_t flags_q, flags_d, ev;
  logic irq_q, wake_q, presc_clr_q;
  logic adv, sec_wrap, min_wrap, hour_wrap, day_wrap;
  logic alm1_hit, alm2_hit, sw_uf;

  // The whole block lives on the always-on clock; no system clock reaches it.
  rtc_presc #(.DIV(PRESC_DIV)) u_presc (
    .clk(clk),
    .rst_n(rst_n),
    .xtal(xtal),
    .tk(tk.presc)
  );

  // Carry chain; a load in the same cycle takes priority over the tick.
  // A tick launched by the prescaler on the load edge arrives one cycle later.
  // It is dropped as well, because it would otherwise step the freshly loaded value.
  assign adv = tk.tick & ~time_wr & ~presc_clr_q;
  assign sec_wrap = adv && (sec_q == `RTC_SEC_LAST);
  assign min_wrap = sec_wrap && (min_q == `RTC_MIN_LAST);
  assign hour_wrap = min_wrap && (hour_q == `RTC_HOUR_LAST);
  assign day_wrap = hour_wrap && (day_q == `RTC_DAY_LAST);
  assign sec_n = adv ? 6'(rtc_step(15'(sec_q), 15'(`RTC_SEC_LAST))) : sec_q;
  assign min_n = sec_wrap ? 6'(rtc_step(15'(min_q), 15'(`RTC_MIN_LAST))) : min_q;
  assign hour_n = min_wrap ? 5'(rtc_step(15'(hour_q), 15'(`RTC_HOUR_LAST))) : hour_q;
  assign day_n = hour_wrap ? rtc_step(day_q, `RTC_DAY_LAST) : day_q;

  // Alarms compare the values that the tick is about to produce.
  assign alm1_hit = adv && alarm_en[0] && sec_n == al_sec_q && min_n == al_min_q && hour_n == al_hour_q;
  assign alm2_hit = adv && alarm_en[1] && sec_n == al_sec_q && min_n == al_min_q && hour_n == al_hour_q
                    && day_n == al_day_q;
  assign sw_uf = tk.tick && !sw_wr && (sw_st_q == RTC_SW_RUN) && sw_en && (sw_q == `RTC_SW_RST);

  // Event vector; the per-second source fires on every advance.
  assign ev[`RTC_EV_SEC] = adv;
  assign ev[`RTC_EV_MIN] = sec_wrap;
  assign ev[`RTC_EV_HOUR] = min_wrap;
  assign ev[`RTC_EV_DAY] = hour_wrap;
  assign ev[`RTC_EV_ALM1] = alm1_hit;
  assign ev[`RTC_EV_ALM2] = alm2_hit;
  assign ev[`RTC_EV_SW] = sw_uf;
  // A new event beats a clear arriving in the same cycle.
  assign flags_d = (flags_q & ~stat_clr) | ev;

  // Timekeeping counters and the prescaler restart on a time load.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sec_q <= 6'h00;
      min_q <= 6'h00;
      hour_q <= 5'h00;
      day_q <= `RTC_TIME_RST;
      presc_clr_q <= 1'b0;
    end else begin
      presc_clr_q <= time_wr;
      sec_q <= time_wr ? time_sec : sec_n;
      min_q <= time_wr ? time_min : min_n;
      hour_q <= time_wr ? time_hour : hour_n;
      day_q <= time_wr ? time_day : day_n;
    end
  end

  assign tk.presc_clr = presc_clr_q;

  // Alarm value storage.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      al_sec_q <= 6'h00;
      al_min_q <= 6'h00;
      al_hour_q <= 5'h00;
      al_day_q <= `RTC_TIME_RST;
    end else if (alarm_wr) begin
      al_sec_q <= alarm_sec;
      al_min_q <= alarm_min;
      al_hour_q <= alarm_hour;
      al_day_q <= alarm_day;
    end
  end

  // Stopwatch state; after an underflow it rests at zero until reloaded.
  always_comb begin
    sw_st_d = sw_st_q;
    case (sw_st_q)
      RTC_SW_IDLE: if (sw_en) sw_st_d = RTC_SW_RUN;
      RTC_SW_RUN: begin
        if (!sw_en) sw_st_d = RTC_SW_IDLE;
        else if (sw_uf) sw_st_d = RTC_SW_DONE;
      end
      RTC_SW_DONE: if (!sw_en) sw_st_d = RTC_SW_IDLE;
      default: sw_st_d = RTC_SW_IDLE;
    endcase
    if (sw_wr) sw_st_d = sw_en ? RTC_SW_RUN : RTC_SW_IDLE;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sw_st_q <= RTC_SW_IDLE;
      sw_q <= `RTC_SW_RST;
    end else begin
      sw_st_q <= sw_st_d;
      if (sw_wr) begin
        sw_q <= sw_value;
      end else if (tk.tick && sw_st_q == RTC_SW_RUN && sw_en && sw_q != `RTC_SW_RST) begin
        sw_q <= sw_q - 16'h0001;
      end
    end
  end

  // Sticky flags and the two request outputs.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flags_q <= `RTC_FLAGS_RST;
      irq_q <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      flags_q <= flags_d;
      irq_q <= |(flags_d & irq_en);
      wake_q <= |(flags_d & wake_en);
    end
  end

  assign cur_sec = sec_q;
  assign cur_min = min_q;
  assign cur_hour = hour_q;
  assign cur_day = day_q;
  assign sw_count = sw_q;
  assign stat_flags = flags_q;
  assign irq = irq_q;
  assign wake_req = wake_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_sec_count;
    tk.tick && !time_wr && !tk.presc_clr && sec_q != `RTC_SEC_LAST |=>
      sec_q == $past(sec_q) + 6'h01 && min_q == $past(min_q);
  endproperty
  a_sec_count: assert property (p_sec_count) else $error("seconds did not advance");

  property p_min_carry;
    tk.tick && !time_wr && !tk.presc_clr && sec_q == `RTC_SEC_LAST && min_q != `RTC_MIN_LAST |=>
      sec_q == 6'h00 && min_q == $past(min_q) + 6'h01;
  endproperty
  a_min_carry: assert property (p_min_carry) else $error("minute carry wrong");

  property p_day_carry;
    hour_wrap && day_q != `RTC_DAY_LAST |=> hour_q == 5'h00 && day_q == $past(day_q) + 15'h0001;
  endproperty
  a_day_carry: assert property (p_day_carry) else $error("day carry wrong");

  // The last day wraps back to the first one together with the hours.
  property p_day_wrap;
    day_wrap |=> hour_q == 5'h00 && day_q == 15'h0000;
  endproperty
  a_day_wrap: assert property (p_day_wrap) else $error("day counter did not wrap");

  property p_min_flag;
    sec_wrap |=> stat_flags[`RTC_EV_MIN] && min_q != $past(min_q);
  endproperty
  a_min_flag: assert property (p_min_flag) else $error("minute flag missing");

  property p_alarm1;
    adv && alarm_en[0] && sec_n == al_sec_q && min_n == al_min_q && hour_n == al_hour_q |=>
      stat_flags[`RTC_EV_ALM1] && sec_q == $past(al_sec_q);
  endproperty
  a_alarm1: assert property (p_alarm1) else $error("daily alarm missed");

  property p_alarm2_day;
    stat_flags[`RTC_EV_ALM2] && !$past(stat_flags[`RTC_EV_ALM2]) |-> day_q == $past(al_day_q) && $past(alarm_en[1]);
  endproperty
  a_alarm2_day: assert property (p_alarm2_day) else $error("dated alarm on wrong day");

  property p_alarm_disabled;
    !alarm_en[0] && !stat_flags[`RTC_EV_ALM1] |=> !stat_flags[`RTC_EV_ALM1];
  endproperty
  a_alarm_disabled: assert property (p_alarm_disabled) else $error("disabled alarm fired");

  property p_sw_dec;
    tk.tick && !sw_wr && sw_en && sw_st_q == RTC_SW_RUN && sw_q != 16'h0000 |=> sw_q == $past(sw_q) - 16'h0001;
  endproperty
  a_sw_dec: assert property (p_sw_dec) else $error("stopwatch did not count down");

  sequence s_sw_at_zero;
    tk.tick && !sw_wr && sw_en && sw_st_q == RTC_SW_RUN && sw_q == 16'h0000;
  endsequence
  sequence s_sw_flagged;
    stat_flags[`RTC_EV_SW] && sw_st_q == RTC_SW_DONE;
  endsequence
  property p_sw_uf;
    s_sw_at_zero |=> s_sw_flagged;
  endproperty
  a_sw_uf: assert property (p_sw_uf) else $error("stopwatch underflow lost");

  property p_sticky;
    stat_flags[`RTC_EV_SEC] && !stat_clr[`RTC_EV_SEC] |=> stat_flags[`RTC_EV_SEC];
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped without clear");

  property p_irq_or;
    ##1 irq == |(stat_flags & $past(irq_en));
  endproperty
  a_irq_or: assert property (p_irq_or) else $error("interrupt not the OR of enabled flags");

  property p_wake;
    ##1 wake_req == |(stat_flags & $past(wake_en));
  endproperty
  a_wake: assert property (p_wake) else $error("wakeup request mismatch");

  property p_load;
    time_wr |=> sec_q == $past(time_sec) && day_q == $past(time_day) ##1
      (!tk.tick && ($past(time_wr) || sec_q == $past(sec_q)));
  endproperty
  a_load: assert property (p_load) else $error("time load not taken");

endmodule : rtc_top

/* pkg/rtc_regs.svh */
`ifndef RTC_REGS_SVH
`define RTC_REGS_SVH

// Crystal and tick rates in hertz.
`define RTC_XTAL_HZ 32768
`define RTC_TICK_HZ 1
// Crystal edges per one-second tick.
`define RTC_PRESC_DIV (`RTC_XTAL_HZ / `RTC_TICK_HZ)

// Last value of each timekeeping field before it wraps.
`define RTC_SEC_LAST 6'h3b
`define RTC_MIN_LAST 6'h3b
`define RTC_HOUR_LAST 5'h17
`define RTC_DAY_LAST 15'h7fff

// Reset values of the counters and of the stopwatch.
`define RTC_TIME_RST 15'h0000
`define RTC_SW_RST 16'h0000
`define RTC_FLAGS_RST 7'h00

// Event and flag bit positions.
`define RTC_EV_SEC 0
`define RTC_EV_MIN 1
`define RTC_EV_HOUR 2
`define RTC_EV_DAY 3
`define RTC_EV_ALM1 4
`define RTC_EV_ALM2 5
`define RTC_EV_SW 6
`define RTC_EV_NUM 7

`endif

/* pkg/rtc_pkg.sv */
package rtc_pkg;

  typedef logic [5:0] rtc_sec_t;
  typedef logic [4:0] rtc_hour_t;
  typedef logic [14:0] rtc_day_t;
  typedef logic [15:0] rtc_sw_t;
  typedef logic [6:0] rtc_ev_t;

  // Stopwatch state, one-hot.
  typedef enum logic [2:0] {
    RTC_SW_IDLE = 3'b001,
    RTC_SW_RUN = 3'b010,
    RTC_SW_DONE = 3'b100
  } rtc_sw_state_t;

endpackage : rtc_pkg

/* pkg/rtc_tick_if.sv */
`timescale 1ns/1ns

// Carries the one-second tick from the prescaler and its restart request back.
interface rtc_tick_if;
  logic tick;
  logic presc_clr;
  modport presc (output tick, input presc_clr);
  modport core (input tick, output presc_clr);
endinterface : rtc_tick_if

/* rtl/rtc_presc.sv */
`timescale 1ns/1ns
`include "rtc_regs.svh"

module rtc_presc #(
  parameter int unsigned DIV = `RTC_PRESC_DIV
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Crystal level from the pin.
  input wire logic xtal,
  // Tick towards the counters.
  rtc_tick_if.presc tk
);
  import rtc_pkg::*;

  localparam logic [15:0] DIV_LAST = 16'(DIV - 1);

  logic s1_q, s2_q, s3_q, lvl_q, lvl_prev_q, tick_q;
  logic [15:0] cnt_q;
  logic xtal_rise;

  // Three-stage capture; the level is accepted only while the last two agree.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      lvl_q <= 1'b0;
      lvl_prev_q <= 1'b0;
    end else begin
      s1_q <= xtal;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        lvl_q <= s3_q;
      end
      lvl_prev_q <= lvl_q;
    end
  end

  assign xtal_rise = lvl_q & ~lvl_prev_q;

  // Counts crystal edges; a restart keeps a freshly written second whole.
  always_ff @(posedge clk) begin
    if (!rst_n || tk.presc_clr) begin
      cnt_q <= 16'h0000;
      tick_q <= 1'b0;
    end else begin
      tick_q <= xtal_rise && (cnt_q == DIV_LAST);
      if (xtal_rise) begin
        cnt_q <= (cnt_q == DIV_LAST) ? 16'h0000 : cnt_q + 16'h0001;
      end
    end
  end

  assign tk.tick = tick_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_tick_cause;
    tick_q |-> $past(xtal_rise) && $past(cnt_q) == DIV_LAST && cnt_q == 16'h0000;
  endproperty
  a_tick_cause: assert property (p_tick_cause) else $error("tick without a full count");

  property p_no_tick_midway;
    xtal_rise && cnt_q != DIV_LAST && !tk.presc_clr |=> !tick_q && cnt_q == $past(cnt_q) + 16'h0001;
  endproperty
  a_no_tick_midway: assert property (p_no_tick_midway) else $error("prescaler miscounted");

endmodule : rtc_presc

/* sim/rtc_tb.sv */
`timescale 1ns/1ns
`include "rtc_regs.svh"

module testbench;
  import rtc_pkg::*;
  // Short prescale so a second lasts 4 crystal periods of 8 clocks each.
  localparam int unsigned DIV = 4;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic xtal = 1'b0;
  logic [2:0] xcnt = 3'h0;
  logic time_wr = 1'b0, alarm_wr = 1'b0, sw_wr = 1'b0, sw_en = 1'b0;
  rtc_day_t time_day = 15'h0000, alarm_day = 15'h0000, cur_day;
  rtc_hour_t time_hour = 5'h00, alarm_hour = 5'h00, cur_hour;
  rtc_sec_t time_min = 6'h00, time_sec = 6'h00, alarm_min = 6'h00, alarm_sec = 6'h00, cur_min, cur_sec;
  logic [1:0] alarm_en = 2'h0;
  rtc_sw_t sw_value = 16'h0000, sw_count;
  rtc_ev_t irq_en = 7'h00, wake_en = 7'h00, stat_clr = 7'h00, stat_flags;
  logic irq, wake_req;
  int err_total = 0;
  int checked = 0;

  rtc_top #(.PRESC_DIV(DIV)) i_dut (.clk(clk), .rst_n(rst_n), .xtal(xtal), .time_wr(time_wr),
    .time_day(time_day), .time_hour(time_hour), .time_min(time_min), .time_sec(time_sec),
    .alarm_wr(alarm_wr), .alarm_day(alarm_day), .alarm_hour(alarm_hour), .alarm_min(alarm_min),
    .alarm_sec(alarm_sec), .alarm_en(alarm_en), .sw_wr(sw_wr), .sw_value(sw_value), .sw_en(sw_en),
    .irq_en(irq_en), .wake_en(wake_en), .stat_clr(stat_clr), .cur_day(cur_day), .cur_hour(cur_hour),
    .cur_min(cur_min), .cur_sec(cur_sec), .sw_count(sw_count), .stat_flags(stat_flags), .irq(irq),
    .wake_req(wake_req));

  // The 50 ns always-on clock.
  initial begin
    forever #25 clk = ~clk;
  end

  // Crystal stand-in, slow enough that every edge clears the synchronizer.
  always @(posedge clk) begin
    xcnt <= xcnt + 3'h1;
    xtal <= xcnt[2];
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude

  // Clears every flag, then waits for the next seconds flag under a bound.
  task automatic wait_tick;
    int n;
    n = 0;
    @(posedge clk) stat_clr <= 7'h7f;
    @(posedge clk) stat_clr <= 7'h00;
    @(negedge clk);
    while (stat_flags[`RTC_EV_SEC] !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    if (n >= 200) check(16'h0001, 16'h0000, "tick missing");
  endtask : wait_tick

  task automatic load_time(input logic [14:0] d, input logic [4:0] h, input logic [5:0] m, input logic [5:0] s);
    @(posedge clk);
    time_wr <= 1'b1;
    time_day <= d;
    time_hour <= h;
    time_min <= m;
    time_sec <= s;
    @(posedge clk) time_wr <= 1'b0;
    @(negedge clk);
    check({cur_day, 1'b0}, {d, 1'b0}, "loaded day");
    check(16'({cur_min, cur_sec}), 16'({m, s}), "loaded minutes and seconds");
    check(16'(cur_hour), 16'(h), "loaded hour");
  endtask : load_time

  task automatic t_reset;
    @(negedge clk);
    check(16'({cur_min, cur_sec}), 16'h0000, "minutes and seconds at reset");
    check(16'(cur_hour), 16'h0000, "hour at reset");
    check(16'(cur_day), 16'(`RTC_TIME_RST), "day at reset");
    check(sw_count, `RTC_SW_RST, "stopwatch at reset");
    check(16'({irq, wake_req, stat_flags}), 16'(`RTC_FLAGS_RST), "flags at reset");
    $display("test reset done");
  endtask : t_reset

  // Tick spacing follows the prescaler and the seconds count steps by one.
  task automatic t_period;
    time t0;
    logic [5:0] s0;
    wait_tick();
    t0 = $time;
    s0 = cur_sec;
    wait_tick();
    check(16'(($time - t0) / 50), 16'(DIV * 8), "tick spacing");
    check(16'(cur_sec), 16'(s0 + 6'h01), "second step");
    $display("test period done");
  endtask : t_period

  // Full cascade from the last second of the last day back to zero.
  task automatic t_roll;
    load_time(`RTC_DAY_LAST, `RTC_HOUR_LAST, `RTC_MIN_LAST, 6'h3a);
    wait_tick();
    check(16'(cur_sec), 16'(`RTC_SEC_LAST), "second before wrap");
    check(16'(stat_flags), 16'h0001, "only second event");
    wait_tick();
    check(16'({cur_min, cur_sec}), 16'h0000, "minute and second wrap");
    check(16'(cur_hour), 16'h0000, "hour wrap");
    check(16'(cur_day), 16'h0000, "day wrap");
    check(16'(stat_flags), 16'h000f, "rollover events");
    @(negedge clk);
    check(16'(irq), 16'h0000, "masked events stay silent");
    $display("test rollover done");
  endtask : t_roll

  // Alarm disabled, daily match on a wrong day, then both on the right day.
  task automatic t_alarm;
    logic [1:0] en [3] = '{2'h0, 2'h3, 2'h3};
    logic [14:0] dy [3] = '{15'h0005, 15'h0003, 15'h0005};
    logic [6:0] ex [3] = '{7'h01, 7'h11, 7'h31};
    @(posedge clk);
    alarm_wr <= 1'b1;
    alarm_day <= 15'h0005;
    alarm_hour <= 5'h01;
    alarm_min <= 6'h02;
    alarm_sec <= 6'h03;
    @(posedge clk) alarm_wr <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      @(posedge clk) alarm_en <= en[i];
      load_time(dy[i], 5'h01, 6'h02, 6'h02);
      wait_tick();
      check(16'(stat_flags), 16'(ex[i]), "alarm flags");
    end
    @(posedge clk) alarm_en <= 2'h0;
    $display("test alarm done");
  endtask : t_alarm

  // Countdown to zero, underflow flag, hold at zero, freeze when disabled.
  task automatic t_stopwatch;
    logic [15:0] ec [3] = '{16'h0001, 16'h0000, 16'h0000};
    @(posedge clk);
    sw_wr <= 1'b1;
    sw_value <= 16'h0002;
    sw_en <= 1'b1;
    @(posedge clk) sw_wr <= 1'b0;
    @(negedge clk) check(sw_count, 16'h0002, "stopwatch load");
    for (int i = 0; i < 3; i++) begin
      wait_tick();
      check(sw_count, ec[i], "stopwatch count");
      check(16'(stat_flags[`RTC_EV_SW]), 16'(i == 2), "underflow flag");
    end
    @(posedge clk) sw_en <= 1'b0;
    @(posedge clk) sw_wr <= 1'b1;
    @(posedge clk) sw_wr <= 1'b0;
    wait_tick();
    check(sw_count, 16'h0002, "stopwatch held");
    check(16'(stat_flags[`RTC_EV_SW]), 16'h0000, "no flag when off");
    $display("test stopwatch done");
  endtask : t_stopwatch

  // Interrupt and wakeup follow enabled sticky flags until cleared.
  task automatic t_irq;
    @(posedge clk);
    irq_en <= 7'h01;
    wake_en <= 7'h02;
    load_time(15'h0001, 5'h02, 6'h03, 6'h3b);
    wait_tick();
    repeat (5) @(negedge clk);
    check(16'(stat_flags[`RTC_EV_SEC]), 16'h0001, "flag sticky");
    check(16'({irq, wake_req}), 16'h0003, "irq and wakeup");
    @(posedge clk) stat_clr <= 7'h01;
    @(posedge clk) stat_clr <= 7'h00;
    @(posedge clk);
    @(negedge clk);
    check(16'({stat_flags[1:0], irq, wake_req}), 16'h0009, "clear one flag");
    @(posedge clk) wake_en <= 7'h00;
    @(posedge clk);
    @(negedge clk);
    check(16'(wake_req), 16'h0000, "wakeup masked");
    $display("test irq done");
  endtask : t_irq

  // Main sequence.
  initial begin
    repeat (7) @(posedge clk);
    t_reset();
    @(posedge clk) rst_n <= 1'b1;
    t_period();
    t_roll();
    t_alarm();
    t_stopwatch();
    t_irq();
    conclude();
  end

  // Watchdog; the sequence needs only about a dozen ticks' worth of cycles.
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    $display("unexpected at %0t: watchdog expired", $time);
    conclude();
  end
endmodule : testbench
